// ### aoc_pkg.sv
/*
  shared constants and types of the four-channel analog output front end
  assumes: one clock domain, byte-wide access to the data and parameter areas
*/
package aoc_pkg;
  localparam int NUM_CH = 4;
  localparam int PRM_BYTES = 6;
  localparam int DIAG_BYTES = 4;
  // parameter area layout
  localparam int PRM_ALARM = 0;
  localparam int PRM_FN_BASE = 2;
  localparam int ALARM_BIT = 6;
  localparam logic [7:0] ALARM_MASK = 8'h40;
  // function numbers
  localparam logic [7:0] FN_KEEP = 8'h00;
  localparam logic [7:0] FN_OFF = 8'hFF;
  localparam logic [7:0] FN_F_BI10V = 8'h01;
  localparam logic [7:0] FN_F_BI20MA = 8'h03;
  localparam logic [7:0] FN_F_4_20MA = 8'h04;
  localparam logic [7:0] FN_F_0_10V = 8'h05;
  localparam logic [7:0] FN_F_0_20MA = 8'h06;
  localparam logic [7:0] FN_S_BI10V = 8'h09;
  localparam logic [7:0] FN_S_1_5V = 8'h0A;
  localparam logic [7:0] FN_S_BI20MA = 8'h0B;
  localparam logic [7:0] FN_S_4_20MA = 8'h0C;
  localparam logic [7:0] FN_S_0_10V = 8'h0D;
  localparam logic [7:0] FN_S_0_20MA = 8'h0E;
  localparam logic [7:0] FN_S_BI4V = 8'h10;
  localparam logic [7:0] FN_S_BI400MV = 8'h11;
  // full-scale codes: 27648 signed word, 16384 flagged word
  localparam logic [15:0] FS_SIGNED = 16'h6C00;
  localparam logic [15:0] FS_FLAGGED = 16'h4000;
  localparam logic [15:0] CODE_NEG_FS = 16'h9400;
  localparam logic [15:0] FLAG_MASK = 16'hFFF8;
  // spans and offsets in microvolt or nanoampere
  localparam logic [31:0] SPAN_10V = 32'h0098_9680;
  localparam logic [31:0] SPAN_4V = 32'h003D_0900;
  localparam logic [31:0] SPAN_400MV = 32'h0006_1A80;
  localparam logic [31:0] SPAN_20MA = 32'h0131_2D00;
  localparam logic [31:0] SPAN_16MA = 32'h00F4_2400;
  localparam logic [31:0] OFS_1V = 32'h000F_4240;
  localparam logic [31:0] OFS_4MA = 32'h003D_0900;
  // diagnostic byte layout
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam int DG_MOD_BIT = 0;
  localparam int DG_EXT_BIT = 2;
  localparam int DG_CHAN_BIT = 3;
  localparam int DG_INFO_BIT = 4;
  typedef enum logic {AOC_LOAD, AOC_RUN} aoc_phase_t;
  typedef enum logic {AOC_TX_IDLE, AOC_TX_SEND} aoc_tx_t;
endpackage : aoc_pkg

// ### aoc_scale.sv
/*
  per-channel scaling of an output word to a setpoint in uV or nA
  assumes: purely combinational; the caller registers the result
*/
module aoc_scale (
  input wire logic [15:0] code,
  input wire logic [7:0] fn,
  output logic signed [31:0] level,
  output logic is_current,
  output logic fn_ok,
  output logic active
);
  logic flagged;
  logic [15:0] fs;
  logic [15:0] cin;
  logic [31:0] span;
  logic [31:0] ofs;
  logic signed [47:0] prod;
  logic signed [47:0] quot;

  always_comb begin
    span = '0;
    ofs = '0;
    is_current = 1'b0;
    fn_ok = 1'b1;
    active = (fn != aoc_pkg::FN_OFF);
    flagged = (fn <= aoc_pkg::FN_F_0_20MA);
    fs = flagged ? aoc_pkg::FS_FLAGGED : aoc_pkg::FS_SIGNED;
    case (fn)
      aoc_pkg::FN_F_BI10V, aoc_pkg::FN_S_BI10V, aoc_pkg::FN_F_0_10V, aoc_pkg::FN_S_0_10V:
        span = aoc_pkg::SPAN_10V;
      aoc_pkg::FN_S_1_5V: begin
        span = aoc_pkg::SPAN_4V;
        ofs = aoc_pkg::OFS_1V;
      end
      aoc_pkg::FN_S_BI4V: span = aoc_pkg::SPAN_4V;
      aoc_pkg::FN_S_BI400MV: span = aoc_pkg::SPAN_400MV;
      aoc_pkg::FN_F_4_20MA, aoc_pkg::FN_S_4_20MA: begin
        span = aoc_pkg::SPAN_16MA;
        ofs = aoc_pkg::OFS_4MA;
        is_current = 1'b1;
      end
      aoc_pkg::FN_F_BI20MA, aoc_pkg::FN_S_BI20MA, aoc_pkg::FN_F_0_20MA, aoc_pkg::FN_S_0_20MA:
      begin
        span = aoc_pkg::SPAN_20MA;
        is_current = 1'b1;
      end
      aoc_pkg::FN_OFF: fn_ok = 1'b1;
      default: fn_ok = 1'b0;
    endcase
    cin = flagged ? (code & aoc_pkg::FLAG_MASK) : code;
    prod = 48'($signed(cin)) * 48'($signed({1'b0, span}));
    quot = prod / 48'($signed({1'b0, fs}));
    level = 32'(quot) + $signed(ofs);
  end
endmodule : aoc_scale

// ### aoc_diag_tx.sv
/*
  sends the diagnostic bytes to the master, one per valid/ready handshake
  assumes: start is a one-cycle pulse given only while busy is low
*/
module aoc_diag_tx #(
  parameter int NBYTES = aoc_pkg::DIAG_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic diag_ready,
  output logic diag_valid,
  output logic [7:0] diag_data,
  output logic busy
);
  localparam int IW = $clog2(NBYTES);
  typedef struct packed {
    aoc_pkg::aoc_tx_t st;
    logic [IW-1:0] idx;
    logic [7:0] hold;
    logic valid;
    logic [7:0] data;
  } aoc_tx_state_t;
  aoc_tx_state_t st_ff;
  aoc_tx_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff.st)
      aoc_pkg::AOC_TX_IDLE: begin
        if (start) begin
          nxt_st.st = aoc_pkg::AOC_TX_SEND;
          nxt_st.hold = byte1;
          nxt_st.valid = 1'b1;
          nxt_st.data = byte0;
          nxt_st.idx = '0;
        end
      end
      default: begin
        if (diag_ready) begin
          nxt_st.idx = st_ff.idx + 1'b1;
          // only the first two bytes carry data
          nxt_st.data = (st_ff.idx == '0) ? st_ff.hold : 8'h00;
          if (st_ff.idx == IW'(NBYTES - 1)) begin
            nxt_st.st = aoc_pkg::AOC_TX_IDLE;
            nxt_st.valid = 1'b0;
            nxt_st.data = 8'h00;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= aoc_tx_state_t'('0);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign diag_valid = st_ff.valid;
  assign diag_data = st_ff.data;
  assign busy = (st_ff.st != aoc_pkg::AOC_TX_IDLE);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  tx_first_a: assert property (start && !busy |=> diag_valid && diag_data == $past(byte0))
    else $error("first diagnostic byte wrong");
  tx_tail_a: assert property (diag_valid && diag_ready && st_ff.idx == IW'(2) |=> diag_data == 8'h00)
    else $error("unassigned diagnostic byte not zero");
  tx_len_a: assert property (diag_valid && diag_ready && st_ff.idx == IW'(NBYTES - 1) |=> !diag_valid)
    else $error("diagnostic frame length wrong");
  tx_done_c: cover property (diag_valid && diag_ready && st_ff.idx == IW'(NBYTES - 1));
endmodule : aoc_diag_tx

// ### aoc_top.sv
/*
  four-channel analog output front end: output data area, parameter area with
  a non-volatile copy, per-channel scaling and the diagnostic sender
  assumes: all inputs synchronous to clk_sys; nv_image holds the stored
  parameter image when rst_n releases; each nv_wr pulse is written back
*/
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - bipolar ten volt: 27648 is full scale
// - one to five volt: 0 to 27648
// - four volt and 400 mV full scale
// - four to twenty mA: 0 to 27648
// - zero based current; negative codes drive negative
// - eight output bytes, one word per channel
// - high byte first at even address
// - six parameter bytes kept in non-volatile store
// - parameter byte 0 bit 6 enables alarms
// - bytes 2 to 5 select channel range
// - enabled alarm on error sends four bytes
// - diagnostic bytes 2 and 3 unassigned
// - byte 0: malfunction, zero, external, channel error
// - byte 1 low nibble is class 0101
// - byte 1 bit 4 flags channel info
// - signed word is two's complement
// - flagged word: three flag bits below value
////////////////////////////////////////////////////////////////////////////////
module aoc_top #(
  parameter logic CHAN_INFO = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic out_wr,
  input wire logic [2:0] out_addr,
  input wire logic [7:0] out_wdata,
  input wire logic prm_wr,
  input wire logic [2:0] prm_addr,
  input wire logic [7:0] prm_wdata,
  output logic [7:0] prm_rdata,
  input wire logic [1:0] diag_addr,
  output logic [7:0] diag_rdata,
  input wire logic [47:0] nv_image,
  output logic nv_wr,
  output logic [47:0] nv_wdata,
  input wire logic fault_module,
  input wire logic fault_external,
  input wire logic diag_ready,
  output logic diag_valid,
  output logic [7:0] diag_data,
  output logic [aoc_pkg::NUM_CH-1:0][31:0] ch_level,
  output logic [aoc_pkg::NUM_CH-1:0] ch_is_current,
  output logic [aoc_pkg::NUM_CH-1:0] ch_active,
  output logic ch_error
);
  typedef struct packed {
    aoc_pkg::aoc_phase_t phase;
    logic [7:0] hi_stage;
    logic [aoc_pkg::NUM_CH-1:0][15:0] word;
    logic [aoc_pkg::PRM_BYTES-1:0][7:0] prm;
    logic nv_wr;
    logic [7:0] prm_rdata;
    logic [7:0] diag_rdata;
    logic err_q;
    logic pend;
    logic start;
    logic [aoc_pkg::NUM_CH-1:0][31:0] level;
    logic [aoc_pkg::NUM_CH-1:0] is_cur;
    logic [aoc_pkg::NUM_CH-1:0] active;
    logic chan_err;
    logic [7:0] diag0;
    logic [7:0] diag1;
  } aoc_state_t;

  aoc_state_t st_ff;
  aoc_state_t nxt_st;

  logic [aoc_pkg::NUM_CH-1:0][31:0] sc_level;
  logic [aoc_pkg::NUM_CH-1:0] sc_cur;
  logic [aoc_pkg::NUM_CH-1:0] sc_ok;
  logic [aoc_pkg::NUM_CH-1:0] sc_act;
  logic tx_busy;
  logic run;
  logic alarm_en;
  logic prm_ok;
  logic chan_err_c;
  logic err_c;
  logic new_evt;
  logic want;
  logic take;

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel scaling

  genvar gi;
  generate
    for (gi = 0; gi < aoc_pkg::NUM_CH; gi++) begin : g_ch
      aoc_scale u_scale (
        .code (st_ff.word[gi]),
        .fn (st_ff.prm[aoc_pkg::PRM_FN_BASE + gi]),
        .level (sc_level[gi]),
        .is_current (sc_cur[gi]),
        .fn_ok (sc_ok[gi]),
        .active (sc_act[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // diagnostic sender

  aoc_diag_tx #(
    .NBYTES (aoc_pkg::DIAG_BYTES)
  ) u_tx (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .start (st_ff.start),
    .byte0 (st_ff.diag0),
    .byte1 (st_ff.diag1),
    .diag_ready (diag_ready),
    .diag_valid (diag_valid),
    .diag_data (diag_data),
    .busy (tx_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.nv_wr = 1'b0;
    run = (st_ff.phase == aoc_pkg::AOC_RUN);
    alarm_en = st_ff.prm[aoc_pkg::PRM_ALARM][aoc_pkg::ALARM_BIT];
    // reserved parameter bytes take no write
    prm_ok = prm_wr && run && (prm_addr == 3'(aoc_pkg::PRM_ALARM)
      || (prm_addr >= 3'(aoc_pkg::PRM_FN_BASE)
      && prm_addr < 3'(aoc_pkg::PRM_BYTES)
      && prm_wdata != aoc_pkg::FN_KEEP));
    chan_err_c = |(sc_act & ~sc_ok);
    err_c = fault_module | fault_external | chan_err_c;
    case (st_ff.phase)
      aoc_pkg::AOC_LOAD: begin
        nxt_st.prm = nv_image;
        nxt_st.prm[aoc_pkg::PRM_ALARM] = nv_image[7:0] & aoc_pkg::ALARM_MASK;
        nxt_st.prm[aoc_pkg::PRM_ALARM + 1] = '0;
        nxt_st.phase = aoc_pkg::AOC_RUN;
      end
      default: begin
        if (out_wr) begin
          // high byte staged, low byte commits
          if (!out_addr[0]) begin
            nxt_st.hi_stage = out_wdata;
          end else begin
            nxt_st.word[out_addr[2:1]] = {st_ff.hi_stage, out_wdata};
          end
        end
        for (int j = 0; j < aoc_pkg::PRM_BYTES; j++) begin
          if (prm_ok && prm_addr == 3'(j)) begin
            // only the alarm enable bit is kept
            if (j == aoc_pkg::PRM_ALARM) begin
              nxt_st.prm[j] = prm_wdata & aoc_pkg::ALARM_MASK;
            end else begin
              nxt_st.prm[j] = prm_wdata;
            end
          end
        end
        nxt_st.nv_wr = prm_ok;
      end
    endcase
    // parameter and diagnostic read ports, one cycle late
    nxt_st.prm_rdata = 8'h00;
    for (int j = 0; j < aoc_pkg::PRM_BYTES; j++) begin
      if (prm_addr == 3'(j)) begin
        nxt_st.prm_rdata = st_ff.prm[j];
      end
    end
    nxt_st.diag_rdata = 8'h00;
    if (diag_addr == 2'h0) begin
      nxt_st.diag_rdata = st_ff.diag0;
    end else if (diag_addr == 2'h1) begin
      nxt_st.diag_rdata = st_ff.diag1;
    end
    nxt_st.level = sc_level;
    nxt_st.is_cur = sc_cur;
    nxt_st.active = sc_act;
    nxt_st.chan_err = chan_err_c;
    nxt_st.diag0 = 8'h00;
    nxt_st.diag0[aoc_pkg::DG_MOD_BIT] = fault_module;
    nxt_st.diag0[aoc_pkg::DG_EXT_BIT] = fault_external;
    nxt_st.diag0[aoc_pkg::DG_CHAN_BIT] = chan_err_c;
    // class code of an analog module
    nxt_st.diag1 = {4'h0, aoc_pkg::CLASS_ANALOG};
    nxt_st.diag1[aoc_pkg::DG_INFO_BIT] = CHAN_INFO;
    // new error while enabled starts a frame
    nxt_st.err_q = err_c;
    new_evt = run && err_c && !st_ff.err_q && alarm_en;
    want = st_ff.pend || new_evt;
    take = want && !tx_busy && !st_ff.start && alarm_en;
    nxt_st.start = take;
    nxt_st.pend = want && !take && alarm_en;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= aoc_state_t'('0);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prm_rdata = st_ff.prm_rdata;
  assign diag_rdata = st_ff.diag_rdata;
  assign nv_wr = st_ff.nv_wr;
  assign nv_wdata = st_ff.prm;
  assign ch_level = st_ff.level;
  assign ch_is_current = st_ff.is_cur;
  assign ch_active = st_ff.active;
  assign ch_error = st_ff.chan_err;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  out_word_a: assert property (
    run && out_wr && out_addr[0]
    |=> st_ff.word[$past(out_addr[2:1])] == {$past(st_ff.hi_stage), $past(out_wdata)})
    else $error("channel word not committed from staged high byte");

  out_high_a: assert property (
    run && out_wr && !out_addr[0]
    |=> st_ff.word == $past(st_ff.word) && st_ff.hi_stage == $past(out_wdata))
    else $error("high byte alone changed a channel word");

  prm_rsvd_a: assert property (
    run |-> (st_ff.prm[aoc_pkg::PRM_ALARM] & ~aoc_pkg::ALARM_MASK) == 8'h00
    && st_ff.prm[aoc_pkg::PRM_ALARM + 1] == 8'h00)
    else $error("reserved parameter bits not zero");

  alarm_push_a: assert property (
    prm_wr && run && prm_addr == 3'(aoc_pkg::PRM_ALARM)
    |=> nv_wr && nv_wdata[7:0] == ($past(prm_wdata) & aoc_pkg::ALARM_MASK))
    else $error("alarm byte not stored and pushed");

  fn_keep_a: assert property (
    prm_wr && run && prm_addr == 3'(aoc_pkg::PRM_FN_BASE) && prm_wdata == aoc_pkg::FN_KEEP
    |=> !nv_wr && st_ff.prm[aoc_pkg::PRM_FN_BASE] == $past(st_ff.prm[aoc_pkg::PRM_FN_BASE]))
    else $error("function 00h altered the stored function");

  nv_quiet_a: assert property (
    !prm_wr |=> !nv_wr)
    else $error("store written without a parameter write");

  diag_gate_a: assert property (
    st_ff.start |-> $past(alarm_en) && !tx_busy)
    else $error("diagnostic frame started while alarms inhibited");

  diag_send_a: assert property (
    new_evt && !st_ff.pend && !st_ff.start && !tx_busy
    |-> ##2 diag_valid && diag_data == $past(st_ff.diag0))
    else $error("error did not start a diagnostic frame in two cycles");

  diag_byte0_a: assert property (
    run |=> st_ff.diag0 == {4'h0, $past(chan_err_c), $past(fault_external), 1'b0,
    $past(fault_module)})
    else $error("fault summary byte wrong");

  diag_byte1_a: assert property (
    run |-> st_ff.diag1 == {3'h0, CHAN_INFO, aoc_pkg::CLASS_ANALOG})
    else $error("module class byte wrong");

  lvl_s10_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE] == aoc_pkg::FN_S_BI10V
    && st_ff.word[0] == aoc_pkg::FS_SIGNED |=> ch_level[0] == aoc_pkg::SPAN_10V)
    else $error("ten volt full scale wrong");

  lvl_15v_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE + 1] == aoc_pkg::FN_S_1_5V
    && st_ff.word[1] == '0 |=> ch_level[1] == aoc_pkg::OFS_1V)
    else $error("one volt base wrong");

  lvl_4v_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE + 2] == aoc_pkg::FN_S_BI4V
    && st_ff.word[2] == aoc_pkg::FS_SIGNED |=> ch_level[2] == aoc_pkg::SPAN_4V)
    else $error("four volt full scale wrong");

  lvl_420_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE + 3] == aoc_pkg::FN_S_4_20MA
    && st_ff.word[3] == aoc_pkg::FS_SIGNED
    |=> ch_level[3] == aoc_pkg::SPAN_16MA + aoc_pkg::OFS_4MA && ch_is_current[3])
    else $error("twenty mA top of live-zero range wrong");

  lvl_neg_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE + 2] == aoc_pkg::FN_S_BI20MA
    && st_ff.word[2] == aoc_pkg::CODE_NEG_FS
    |=> ch_level[2] + aoc_pkg::SPAN_20MA == '0)
    else $error("negative full scale current wrong");

  lvl_sign_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE] == aoc_pkg::FN_S_BI10V && st_ff.word[0][15]
    |=> $signed(ch_level[0]) <= 0)
    else $error("negative code gave positive level");

  lvl_flag_a: assert property (
    st_ff.prm[aoc_pkg::PRM_FN_BASE] == aoc_pkg::FN_F_BI10V
    && (st_ff.word[0] & aoc_pkg::FLAG_MASK) == aoc_pkg::FS_FLAGGED
    |=> ch_level[0] == aoc_pkg::SPAN_10V)
    else $error("flag bits changed the level");

  frame_c: cover property (st_ff.start ##1 diag_valid);
  commit_c: cover property (run && out_wr && out_addr[0]);
  fn_set_c: cover property (prm_ok && prm_addr == 3'(aoc_pkg::PRM_FN_BASE));
  ch_off_c: cover property (run && !ch_active[3]);
endmodule : aoc_top

// ### aoc_master_model.sv
/*
  bus master model: takes diagnostic bytes by valid/ready handshake
  assumes: slow selects a stalling ready pattern; ready changes after each edge
*/
module aoc_master_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic diag_valid,
  input wire logic [7:0] diag_data,
  output logic diag_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q[$];
  logic [2:0] stall_ff;
  //////////////////////////////////////////////////////////////////////////////
  // collect diagnostic bytes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      diag_ready <= 1'b0;
      stall_ff <= 3'h0;
    end else begin
      if (diag_valid === 1'b1 && diag_ready) begin
        rx_q.push_back(diag_data);
      end
      stall_ff <= stall_ff + 3'h1;
      // ready one cycle in eight when stalling
      diag_ready <= !slow || (stall_ff == 3'h5);
    end
  end
endmodule : aoc_master_model

// ### tb_top.sv
/*
  self-checking bench of the four-channel analog output front end
  assumes: aoc_pkg, aoc_top and aoc_master_model compiled first; one 40 MHz clock
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic out_wr = 1'b0;
  logic [2:0] out_addr = 3'h0;
  logic [7:0] out_wdata = 8'h00;
  logic prm_wr = 1'b0;
  logic [2:0] prm_addr = 3'h0;
  logic [7:0] prm_wdata = 8'h00;
  logic [7:0] prm_rdata;
  logic [1:0] diag_addr = 2'h0;
  logic [7:0] diag_rdata;
  logic [47:0] nv_image = 48'h0C11_0A09_AAFF;
  logic nv_wr;
  logic [47:0] nv_wdata;
  logic fault_module = 1'b0;
  logic fault_external = 1'b0;
  logic slow = 1'b0;
  logic diag_ready;
  logic diag_valid;
  logic [7:0] diag_data;
  logic [aoc_pkg::NUM_CH-1:0][31:0] ch_level;
  logic [aoc_pkg::NUM_CH-1:0] ch_is_current;
  logic [aoc_pkg::NUM_CH-1:0] ch_active;
  logic ch_error;
  int n_mismatch = 0;
  int check_count = 0;
  int nv_cnt = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'h0000_8F95;
  logic [7:0] fns [13] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11,
    8'h01, 8'h03, 8'h04, 8'h05, 8'h06};

  aoc_top aoc_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .out_wr(out_wr), .out_addr(out_addr),
    .out_wdata(out_wdata), .prm_wr(prm_wr), .prm_addr(prm_addr), .prm_wdata(prm_wdata),
    .prm_rdata(prm_rdata), .diag_addr(diag_addr), .diag_rdata(diag_rdata),
    .nv_image(nv_image), .nv_wr(nv_wr), .nv_wdata(nv_wdata), .fault_module(fault_module),
    .fault_external(fault_external), .diag_ready(diag_ready), .diag_valid(diag_valid),
    .diag_data(diag_data), .ch_level(ch_level), .ch_is_current(ch_is_current),
    .ch_active(ch_active), .ch_error(ch_error)
  );
  aoc_master_model aoc_master_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .diag_valid(diag_valid),
    .diag_data(diag_data), .diag_ready(diag_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  always #12.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (nv_wr === 1'b1) begin
      nv_cnt++;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // {is_current, level} in uV or nA
  function automatic logic [32:0] exp_lv(input logic [7:0] fn, input logic [15:0] code);
    longint s = 0;
    longint o = 0;
    longint f = longint'(aoc_pkg::FS_SIGNED);
    logic cur = 1'b0;
    logic [15:0] w = code;
    cur = fn inside {8'h03, 8'h04, 8'h06, 8'h0B, 8'h0C, 8'h0E};
    if (fn < 8'h07) begin
      w = code & aoc_pkg::FLAG_MASK;
      f = longint'(aoc_pkg::FS_FLAGGED);
    end
    if (fn == 8'h0A) o = longint'(aoc_pkg::OFS_1V);
    if (fn inside {8'h04, 8'h0C}) o = longint'(aoc_pkg::OFS_4MA);
    case (fn)
      8'h01, 8'h05, 8'h09, 8'h0D: s = longint'(aoc_pkg::SPAN_10V);
      8'h0A, 8'h10: s = longint'(aoc_pkg::SPAN_4V);
      8'h11: s = longint'(aoc_pkg::SPAN_400MV);
      8'h03, 8'h06, 8'h0B, 8'h0E: s = longint'(aoc_pkg::SPAN_20MA);
      8'h04, 8'h0C: s = longint'(aoc_pkg::SPAN_16MA);
      default: s = 0;
    endcase
    return {cur, 32'(longint'($signed(w)) * s / f + o)};
  endfunction : exp_lv

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // high byte then low byte, back to back
  task automatic wr_word(input int ch, input logic [15:0] code);
    @(negedge clk_sys);
    out_wr = 1'b1;
    out_addr = 3'(2 * ch);
    out_wdata = code[15:8];
    @(negedge clk_sys);
    out_addr = 3'(2 * ch + 1);
    out_wdata = code[7:0];
    @(negedge clk_sys);
    out_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : wr_word

  task automatic wp(input logic [2:0] a, input logic [7:0] d, input int pulses);
    int n0 = nv_cnt;
    @(negedge clk_sys);
    prm_wr = 1'b1;
    prm_addr = a;
    prm_wdata = d;
    @(negedge clk_sys);
    prm_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(48'(nv_cnt - n0), 48'(pulses));
  endtask : wp

  task automatic rd(input logic is_diag, input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    prm_addr = a;
    diag_addr = a[1:0];
    repeat (2) @(negedge clk_sys);
    chk(48'(is_diag ? diag_rdata : prm_rdata), 48'(exp));
  endtask : rd

  task automatic lv(input int ch, input logic [7:0] fn, input logic [15:0] code);
    logic [32:0] e;
    e = exp_lv(fn, code);
    wr_word(ch, code);
    chk(48'(ch_level[ch]), 48'(e[31:0]));
    chk(48'({ch_active[ch], ch_is_current[ch]}), 48'({1'b1, e[32]}));
  endtask : lv

  task automatic frame(input logic [7:0] b0);
    for (int k = 0; k < 300 && aoc_master_model_inst.rx_q.size() < 4; k++) begin
      @(negedge clk_sys);
    end
    repeat (10) @(negedge clk_sys);
    chk(48'(aoc_master_model_inst.rx_q.size()), 48'h4);
    chk(48'({aoc_master_model_inst.rx_q[0], aoc_master_model_inst.rx_q[1],
      aoc_master_model_inst.rx_q[2], aoc_master_model_inst.rx_q[3]}),
      48'({b0, 8'h15, 16'h0000}));
    aoc_master_model_inst.rx_q.delete();
  endtask : frame

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(nv_wdata, 48'h0C11_0A09_0040);
    rd(1'b0, 3'h2, 8'h09);
    wp(3'h1, 8'hA5, 0);
    wp(3'h2, 8'h00, 0);
    wp(3'h0, 8'hFF, 1);
    rd(1'b0, 3'h0, 8'h40);
    rd(1'b0, 3'h1, 8'h00);
    rd(1'b0, 3'h7, 8'h00);
    chk(nv_wdata, 48'h0C11_0A09_0040);
    // every range function number with corner and random codes
    for (int i = 0; i < 13; i++) begin
      wp(3'(2 + i % 4), fns[i], 1);
      lv(i % 4, fns[i], 16'h6C00);
      lv(i % 4, fns[i], 16'h9400);
      lv(i % 4, fns[i], 16'h0000);
      lv(i % 4, fns[i], 16'h4007);
      for (int j = 0; j < 3; j++) begin
        rnd = lfsr(rnd);
        lv(i % 4, fns[i], rnd[15:0]);
      end
    end
    // lone high byte leaves the word alone
    lv(0, 8'h06, 16'h2000);
    @(negedge clk_sys);
    out_wr = 1'b1;
    out_wdata = 8'h12;
    out_addr = 3'h0;
    @(negedge clk_sys);
    out_wr = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(48'(ch_level[0]), 48'(exp_lv(8'h06, 16'h2000) & 33'h0FFFF_FFFF));
    wp(3'h5, 8'hFF, 1);
    chk(48'({ch_active[3], ch_level[3]}), 48'h0);
    fault_external = 1'b1;
    frame(8'h04);
    rd(1'b1, 3'h0, 8'h04);
    rd(1'b1, 3'h1, 8'h15);
    rd(1'b1, 3'h2, 8'h00);
    rd(1'b1, 3'h3, 8'h00);
    fault_external = 1'b0;
    @(negedge clk_sys);
    slow = 1'b1;
    fault_module = 1'b1;
    frame(8'h01);
    fault_module = 1'b0;
    slow = 1'b0;
    wp(3'h4, 8'h08, 1);
    chk(48'({ch_error, ch_level[2]}), 48'h1_0000_0000);
    frame(8'h08);
    wp(3'h4, 8'h09, 1);
    wp(3'h0, 8'h00, 1);
    fault_module = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk(48'(aoc_master_model_inst.rx_q.size()), 48'h0);
    end_sim();
  end
endmodule : tb_top
